// >>> logic/pew_map.svh
// Purpose: Widths, field positions and timing counts for the page-write host.
// Assumes: A 50 MHz system clock.
// Notes: Times are kept in their own unit; cycle counts derive from them.
`ifndef PEW_MAP_SVH
`define PEW_MAP_SVH
`define PEW_CLK_NS 20
`define PEW_T_WE_LOW_NS 100
`define PEW_T_ACC_NS 150
`define PEW_T_LOAD_NS 150000
`define PEW_T_WC_NS 10000000
`define PEW_LOAD_GUARD 16
`define PEW_PAGE_LSB 6
`define PEW_ADDR_W 15
`define PEW_TMR_W 24
`define PEW_SEQ_LEN 3
`endif

// >>> logic/pew_pkg.sv
// Purpose: Types shared by the page-write host and its bench.
// Assumes: Nothing beyond the map header.
// Notes: Operation codes are chosen by the encoding order below.
package pew_pkg;
   typedef enum logic [1:0] {OP_READ, OP_WRITE, OP_LOCK, OP_UNLOCK} pew_op_t;
   typedef enum logic [2:0] {S_IDLE, S_WSET, S_WLOW, S_WREL, S_LOAD, S_RACC,
      S_RGAP} pew_state_t;
endpackage

// >>> logic/pew_host.sv
// Purpose: Host controller driving a 32K x 8 page-write EEPROM over its pins.
// Assumes: Pin inputs are synchronous to i_clk_sys; the pad resolves dq.
// Notes: One command at a time; page loads stay open until a last byte or the end of the window.
// Function
// [RULE1] Device drives stored byte when selected, output enabled, strobe high.
// [RULE2] Device floats data whenever select or output enable is high.
// [RULE3] Write starts on a strobe low pulse with select low, enable high.
// [RULE4] Device takes the address on the later falling edge.
// [RULE5] Device takes the data on the first rising edge.
// [RULE6] Programming self-times; reads meanwhile return polling status.
// [RULE7] One to 64 bytes load and program in one period.
// [RULE8] Host presents each further page byte within 150 us.
// [RULE9] Without a further byte in the window, programming starts.
// [RULE10] Host keeps the page address bits equal on every strobe fall; the host strobes lock and prefix sequence bytes at their own addresses.
// [RULE11] Low six bits pick the byte; any order, reload replaces.
// [RULE12] Only loaded bytes of the page are programmed.
// [RULE13] During programming, last byte read returns inverted bit seven.
// [RULE14] During programming, bit six inverts on each successive read.
// [RULE15] No write starts with enable low, select high or strobe high.
// [RULE16] Three-write sequence turns the lock on after one cycle time.
// [RULE17] Locked device still writes data preceded by the enable sequence.
// [RULE18] Lock starts off and persists until the disable sequence.
// [RULE19] Lock sequences follow page timing; their bytes are not stored.
// [RULE20] Locked write without prefix runs the timer, stores nothing.
// [RULE21] Id-mode input maps the top 64 addresses to a separate area.
// [RULE22] Programming ends within 3 ms or 10 ms by speed grade.
// [RULE23] Lock and unlock address and data pairs are design parameters.
`include "pew_map.svh"
`timescale 1ns/1ns
`default_nettype none
module pew_host
#(
   parameter int LOAD_CYC = `PEW_T_LOAD_NS / `PEW_CLK_NS,
   parameter int TWC_CYC = (`PEW_T_WC_NS + `PEW_CLK_NS - 1) / `PEW_CLK_NS,
   parameter logic [44:0] EN_SEQ_ADDR = {15'h0AAA, 15'h0555, 15'h0AAA},
   parameter logic [23:0] EN_SEQ_DATA = {8'hC3, 8'h3C, 8'h5A},
   parameter logic [44:0] DIS_SEQ_ADDR = {15'h0AAA, 15'h0555, 15'h0AAA},
   parameter logic [23:0] DIS_SEQ_DATA = {8'h96, 8'h3C, 8'h5A}
)
(
   input wire logic i_clk_sys,
   input wire logic i_reset_n,
   input wire logic i_cmd_valid,
   input wire pew_pkg::pew_op_t i_cmd_op,
   input wire logic [14:0] i_cmd_addr,
   input wire logic [7:0] i_cmd_data,
   input wire logic i_cmd_prefix,
   input wire logic i_cmd_last,
   input wire logic i_cmd_id,
   output logic o_cmd_ready,
   output logic o_busy,
   output logic o_rd_valid,
   output logic [7:0] o_rd_data,
   output logic o_wr_done,
   output logic o_wr_timeout,
   output logic o_ce_n,
   output logic o_oe_n,
   output logic o_we_n,
   output logic [14:0] o_addr,
   output logic [7:0] o_dq_out,
   output logic o_dq_oe,
   input wire logic [7:0] i_dq_in,
   output logic o_id_mode
);
   localparam logic [3:0] WE_CYC =
      4'((`PEW_T_WE_LOW_NS + `PEW_CLK_NS - 1) / `PEW_CLK_NS);
   localparam logic [3:0] ACC_CYC =
      4'((`PEW_T_ACC_NS + `PEW_CLK_NS - 1) / `PEW_CLK_NS);
   localparam logic [23:0] LOAD_LIM = 24'(LOAD_CYC);
   localparam logic [23:0] OPEN_LIM = 24'(LOAD_CYC - `PEW_LOAD_GUARD);
   localparam logic [23:0] TWC_LIM = 24'(TWC_CYC);

   // Returns {address, data} of one step of the lock or unlock sequence.
   function automatic logic [22:0] seq_pair(input logic dis,
      input logic [1:0] idx);
      logic [44:0] a;
      logic [23:0] d;
      a = dis ? DIS_SEQ_ADDR : EN_SEQ_ADDR;
      d = dis ? DIS_SEQ_DATA : EN_SEQ_DATA;
      seq_pair = {a[idx*15 +: 15], d[idx*8 +: 8]}; // [RULE23]
   endfunction

   pew_pkg::pew_state_t state_ff, nxt_state;
   logic [3:0] phase_ff, nxt_phase;
   logic [23:0] tmr_ff, nxt_tmr;
   logic [1:0] idx_ff, nxt_idx;
   logic seq_on_ff, nxt_seq_on, dis_ff, nxt_dis, has_data_ff, nxt_has_data;
   logic last_ff, nxt_last, poll_ff, nxt_poll, first_ff, nxt_first;
   logic known_ff, nxt_known, prev6_ff, nxt_prev6;
   logic [8:0] page_ff, nxt_page;
   logic [14:0] last_addr_ff, nxt_last_addr, dat_addr_ff, nxt_dat_addr;
   logic [7:0] last_data_ff, nxt_last_data, dat_data_ff, nxt_dat_data;
   logic nxt_ready, nxt_busy, nxt_rd_valid, nxt_wr_done, nxt_wr_timeout;
   logic [7:0] nxt_rd_data, nxt_dq_out;
   logic [14:0] nxt_addr;
   logic nxt_ce_n, nxt_oe_n, nxt_we_n, nxt_dq_oe, nxt_id_mode;
   logic fit, take, poll_ok;

   always_comb
   begin
      nxt_state = state_ff;
      nxt_phase = phase_ff;
      nxt_tmr = tmr_ff;
      nxt_idx = idx_ff;
      nxt_seq_on = seq_on_ff;
      nxt_dis = dis_ff;
      nxt_has_data = has_data_ff;
      nxt_last = last_ff;
      nxt_poll = poll_ff;
      nxt_first = first_ff;
      nxt_known = known_ff;
      nxt_prev6 = prev6_ff;
      nxt_page = page_ff;
      nxt_last_addr = last_addr_ff;
      nxt_last_data = last_data_ff;
      nxt_dat_addr = dat_addr_ff;
      nxt_dat_data = dat_data_ff;
      nxt_addr = o_addr;
      nxt_dq_out = o_dq_out;
      nxt_rd_data = o_rd_data;
      nxt_id_mode = o_id_mode;
      nxt_rd_valid = 1'b0;
      nxt_wr_done = 1'b0;
      nxt_wr_timeout = 1'b0;
      // Only a plain write to the open page may join a running load.
      fit = i_cmd_op == pew_pkg::OP_WRITE && !i_cmd_prefix &&
         i_cmd_addr[14:`PEW_PAGE_LSB] == page_ff; // [RULE10] [RULE11]
      take = i_cmd_valid && o_cmd_ready && (state_ff == pew_pkg::S_IDLE || fit);
      poll_ok = !first_ff && i_dq_in[6] == prev6_ff && // [RULE14]
         (!known_ff || i_dq_in[7] == last_data_ff[7]); // [RULE13]
      case (state_ff)
         pew_pkg::S_IDLE:
         begin
            if (take)
            begin
               nxt_id_mode = i_cmd_id; // [RULE21]
               nxt_last = i_cmd_last;
               nxt_page = i_cmd_addr[14:`PEW_PAGE_LSB];
               nxt_known = 1'b0;
               nxt_dat_addr = i_cmd_addr;
               nxt_dat_data = i_cmd_data;
               nxt_has_data = i_cmd_op == pew_pkg::OP_WRITE;
               nxt_dis = i_cmd_op == pew_pkg::OP_UNLOCK;
               nxt_idx = 2'h0;
               nxt_state = pew_pkg::S_WSET;
               case (i_cmd_op)
                  pew_pkg::OP_READ:
                  begin
                     nxt_addr = i_cmd_addr;
                     nxt_poll = 1'b0;
                     nxt_phase = 4'h0;
                     nxt_state = pew_pkg::S_RACC;
                  end
                  pew_pkg::OP_WRITE:
                  begin
                     nxt_seq_on = i_cmd_prefix; // [RULE17]
                     if (i_cmd_prefix)
                        {nxt_addr, nxt_dq_out} = seq_pair(1'b0, 2'h0);
                     else
                        {nxt_addr, nxt_dq_out} = {i_cmd_addr, i_cmd_data};
                  end
                  default:
                  begin
                     nxt_seq_on = 1'b1; // [RULE16] [RULE18]
                     nxt_last = 1'b1;
                     {nxt_addr, nxt_dq_out} = seq_pair(nxt_dis, 2'h0);
                  end
               endcase
            end
         end
         pew_pkg::S_WSET:
         begin
            nxt_phase = 4'h0;
            nxt_state = pew_pkg::S_WLOW; // [RULE3]
         end
         pew_pkg::S_WLOW:
         begin
            if (phase_ff == WE_CYC - 4'h1)
               nxt_state = pew_pkg::S_WREL;
            else
               nxt_phase = phase_ff + 4'h1;
         end
         pew_pkg::S_WREL:
         begin
            nxt_tmr = 24'h0;
            nxt_last_addr = o_addr;
            if (seq_on_ff && idx_ff != 2'(`PEW_SEQ_LEN - 1))
            begin
               nxt_idx = idx_ff + 2'h1;
               {nxt_addr, nxt_dq_out} = seq_pair(dis_ff, nxt_idx);
               nxt_state = pew_pkg::S_WSET; // [RULE19]
            end
            else if (seq_on_ff && has_data_ff)
            begin
               nxt_seq_on = 1'b0;
               {nxt_addr, nxt_dq_out} = {dat_addr_ff, dat_data_ff};
               nxt_state = pew_pkg::S_WSET;
            end
            else
            begin
               // Sequence bytes are never stored, so only data arms bit 7.
               nxt_known = !seq_on_ff;
               nxt_last_data = o_dq_out;
               nxt_seq_on = 1'b0;
               nxt_state = pew_pkg::S_LOAD;
            end
         end
         pew_pkg::S_LOAD:
         begin
            nxt_tmr = tmr_ff + 24'h1;
            if (take)
            begin
               {nxt_addr, nxt_dq_out} = {i_cmd_addr, i_cmd_data}; // [RULE7]
               nxt_last = i_cmd_last;
               nxt_state = pew_pkg::S_WSET;
            end
            else if (tmr_ff >= LOAD_LIM)
            begin
               // Window elapsed: the part is programming now.
               nxt_tmr = 24'h0; // [RULE9]
               nxt_addr = last_addr_ff;
               nxt_poll = 1'b1;
               nxt_first = 1'b1;
               nxt_phase = 4'h0;
               nxt_state = pew_pkg::S_RACC; // [RULE6] [RULE20]
            end
         end
         pew_pkg::S_RACC:
         begin
            if (poll_ff)
               nxt_tmr = tmr_ff + 24'h1;
            if (phase_ff != ACC_CYC - 4'h1)
               nxt_phase = phase_ff + 4'h1;
            else
            begin
               nxt_state = pew_pkg::S_RGAP;
               nxt_prev6 = i_dq_in[6];
               nxt_first = 1'b0;
               if (!poll_ff)
               begin
                  nxt_rd_data = i_dq_in; // [RULE1]
                  nxt_rd_valid = 1'b1;
               end
               else if (poll_ok)
               begin
                  nxt_wr_done = 1'b1;
                  nxt_poll = 1'b0;
               end
               else if (tmr_ff >= TWC_LIM)
               begin
                  nxt_wr_timeout = 1'b1; // [RULE22]
                  nxt_poll = 1'b0;
               end
            end
         end
         pew_pkg::S_RGAP:
         begin
            // A gap cycle makes each poll a distinct read for bit 6.
            nxt_phase = 4'h0;
            if (poll_ff)
            begin
               nxt_tmr = tmr_ff + 24'h1;
               nxt_state = pew_pkg::S_RACC;
            end
            else
               nxt_state = pew_pkg::S_IDLE;
         end
         default:
            nxt_state = pew_pkg::S_IDLE;
      endcase
      nxt_ce_n = !(nxt_state == pew_pkg::S_WSET ||
         nxt_state == pew_pkg::S_WLOW || nxt_state == pew_pkg::S_RACC);
      nxt_we_n = nxt_state != pew_pkg::S_WLOW; // [RULE15]
      nxt_oe_n = nxt_state != pew_pkg::S_RACC; // [RULE2]
      // Data stays driven through the release edge to cover the latch.
      nxt_dq_oe = nxt_state == pew_pkg::S_WSET ||
         nxt_state == pew_pkg::S_WLOW || nxt_state == pew_pkg::S_WREL; // [RULE5]
      nxt_busy = nxt_state != pew_pkg::S_IDLE;
      nxt_ready = nxt_state == pew_pkg::S_IDLE || (nxt_state == pew_pkg::S_LOAD
         && !nxt_last && nxt_tmr < OPEN_LIM); // [RULE8]
   end

   always_ff @(posedge i_clk_sys or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         state_ff <= pew_pkg::S_IDLE;
         phase_ff <= 4'h0;
         tmr_ff <= 24'h0;
         idx_ff <= 2'h0;
         {seq_on_ff, dis_ff, has_data_ff, last_ff} <= 4'h0;
         {poll_ff, first_ff, known_ff, prev6_ff} <= 4'h0;
         page_ff <= 9'h000;
         {last_addr_ff, dat_addr_ff} <= {15'h0000, 15'h0000};
         {last_data_ff, dat_data_ff} <= 16'h0000;
         {o_cmd_ready, o_busy, o_rd_valid, o_wr_done, o_wr_timeout} <= 5'h00;
         o_rd_data <= 8'h00;
         {o_ce_n, o_oe_n, o_we_n, o_dq_oe, o_id_mode} <= 5'h1C;
         o_addr <= 15'h0000;
         o_dq_out <= 8'h00;
      end
      else
      begin
         state_ff <= nxt_state;
         phase_ff <= nxt_phase;
         tmr_ff <= nxt_tmr;
         idx_ff <= nxt_idx;
         {seq_on_ff, dis_ff, has_data_ff, last_ff} <=
            {nxt_seq_on, nxt_dis, nxt_has_data, nxt_last};
         {poll_ff, first_ff, known_ff, prev6_ff} <=
            {nxt_poll, nxt_first, nxt_known, nxt_prev6};
         page_ff <= nxt_page;
         {last_addr_ff, dat_addr_ff} <= {nxt_last_addr, nxt_dat_addr};
         {last_data_ff, dat_data_ff} <= {nxt_last_data, nxt_dat_data};
         {o_cmd_ready, o_busy, o_rd_valid, o_wr_done, o_wr_timeout} <=
            {nxt_ready, nxt_busy, nxt_rd_valid, nxt_wr_done, nxt_wr_timeout};
         o_rd_data <= nxt_rd_data;
         {o_ce_n, o_oe_n, o_we_n, o_dq_oe, o_id_mode} <=
            {nxt_ce_n, nxt_oe_n, nxt_we_n, nxt_dq_oe, nxt_id_mode};
         o_addr <= nxt_addr;
         o_dq_out <= nxt_dq_out;
      end
   end

   default clocking chk_cb @(posedge i_clk_sys); endclocking
   default disable iff (!i_reset_n);

   chk_write_inhibit: assert property (!o_we_n |-> !o_ce_n && o_oe_n) // [RULE15]
      else $error("Strobe low without select or with output enable low.");
   chk_no_contention: assert property (!o_oe_n |-> !o_dq_oe && o_we_n) // [RULE2]
      else $error("Host drives data while the part may drive it.");
   chk_strobe_width: assert property ($fell(o_we_n) |->
      !o_we_n [*5] ##1 o_we_n) // [RULE3]
      else $error("Write strobe low pulse has the wrong width.");
   chk_addr_steady: assert property (!o_we_n && !$past(o_we_n) |->
      $stable(o_addr) && $stable(o_dq_out)) // [RULE4]
      else $error("Address or data moved while the strobe was low.");
   chk_data_at_rise: assert property ($rose(o_we_n) |-> o_dq_oe &&
      $stable(o_dq_out)) // [RULE5]
      else $error("Data not held at the strobe rising edge.");
   chk_same_page: assert property ($fell(o_we_n) && known_ff && !seq_on_ff
      |-> o_addr[14:6] == page_ff) // [RULE10]
      else $error("Page address changed within a load.");
   chk_load_gap: assert property (state_ff == pew_pkg::S_LOAD &&
      nxt_state == pew_pkg::S_WSET |-> tmr_ff < OPEN_LIM) // [RULE8]
      else $error("Next page byte offered after the load window.");
   chk_poll_start: assert property (state_ff == pew_pkg::S_LOAD &&
      tmr_ff >= LOAD_LIM && !take |=> !o_oe_n && o_addr == last_addr_ff) // [RULE9]
      else $error("Polling did not start on the last byte written.");
   chk_poll_bound: assert property (poll_ff && state_ff == pew_pkg::S_RACC
      |-> tmr_ff <= TWC_LIM + 24'h10) // [RULE22]
      else $error("Polling ran past the cycle time bound.");
   chk_done_match: assert property (o_wr_done |-> $past(i_dq_in[6]) ==
      $past(prev6_ff)) // [RULE14]
      else $error("Completion flagged while bit six still toggled.");

   cov_read: cover property (o_rd_valid);
   cov_page_two: cover property (state_ff == pew_pkg::S_LOAD && take);
   cov_lock_done: cover property (o_wr_done && dis_ff == 1'b0 && !known_ff);
   cov_timeout: cover property (o_wr_timeout);
endmodule
`default_nettype wire

// >>> tb/pew_eeprom_model.sv
// Purpose: Behavioural page-write EEPROM that answers the host's pins.
// Assumes: Pins change only just after i_clk_sys edges.
// Notes: Window and program times are counted in clock cycles, not ns.
`timescale 1ns/1ns
`default_nettype none
module pew_eeprom_model
#(
   parameter int LOAD_CYC = 200,
   parameter logic [44:0] EN_A = {15'h0AAA, 15'h0555, 15'h0AAA},
   parameter logic [23:0] EN_D = {8'hC3, 8'h3C, 8'h5A},
   parameter logic [44:0] DIS_A = {15'h0AAA, 15'h0555, 15'h0AAA},
   parameter logic [23:0] DIS_D = {8'h96, 8'h3C, 8'h5A}
)
(
   input wire logic i_clk_sys,
   input wire logic i_ce_n,
   input wire logic i_oe_n,
   input wire logic i_we_n,
   input wire logic [14:0] i_addr,
   input wire logic [7:0] i_dq,
   input wire logic i_id_mode,
   input wire logic i_slow,
   output logic [7:0] o_dq,
   output logic o_dq_oe
);
   logic [7:0] mem [0:32767];
   logic [7:0] idm [0:63];
   logic [7:0] pbuf [0:63];
   logic [63:0] pmask = '0;
   logic [14:0] wa = '0;
   logic [14:0] page = '0;
   logic [7:0] last_d = 8'h00;
   logic prog = 0, tog = 0, oe_q = 1, loading = 0, lock_nx = 0;
   logic locked = 0;
   logic fail = 0, en_ok = 1, dis_ok = 1, idw = 0;
   int seq = 0, lcnt = 0, pcnt = 0;
   wire wr_act = !i_ce_n && !i_we_n && i_oe_n;
   initial
   begin
      foreach (mem[i]) mem[i] = 8'hFF;
      foreach (idm[i]) idm[i] = 8'hFF;
   end
   task automatic take(input logic [14:0] a, input logic [7:0] d);
      logic e;
      logic s;
      e = a == EN_A[seq*15 +: 15] && d == EN_D[seq*8 +: 8];
      s = a == DIS_A[seq*15 +: 15] && d == DIS_D[seq*8 +: 8];
      if (!fail && seq < 3 && ((e && en_ok) || (s && dis_ok)))
      begin
         en_ok = en_ok && e;
         dis_ok = dis_ok && s;
         seq++;
      end
      else
      begin
         fail = 1;
         page = a;
         idw = i_id_mode && a[14:6] == 9'h1FF;
         pbuf[a[5:0]] = d;
         pmask[a[5:0]] = 1'b1;
         last_d = d;
      end
      loading = 1;
      lcnt = 0;
   endtask
   always @(posedge wr_act) wa = i_addr;
   always @(negedge wr_act)
      if ($time > 0 && !prog) take(wa, i_dq);
   always @(posedge i_clk_sys)
   begin
      if (prog && !i_oe_n && !i_ce_n && oe_q) tog = !tog;
      oe_q = i_oe_n;
      if (loading) lcnt++;
      if (loading && lcnt >= LOAD_CYC)
      begin
         loading = 0;
         prog = 1;
         pcnt = 0;
         lock_nx = seq == 3 ? en_ok : locked;
         if (!locked || seq == 3)
            for (int i = 0; i < 64; i++)
               if (pmask[i] && idw)
                  idm[i] = pbuf[i];
               else if (pmask[i])
                  mem[{page[14:6], 6'(i)}] = pbuf[i];
         pmask = '0;
         seq = 0;
         fail = 0;
         en_ok = 1;
         dis_ok = 1;
      end
      else if (prog)
      begin
         pcnt++;
         if (pcnt >= (i_slow ? 600 : 120))
         begin
            prog = 0;
            locked = lock_nx;
         end
      end
   end
   assign o_dq_oe = !i_ce_n && !i_oe_n && i_we_n;
   assign o_dq = prog ? {~last_d[7], tog, last_d[5:0]}
      : (i_id_mode && i_addr[14:6] == 9'h1FF) ? idm[i_addr[5:0]]
      : mem[i_addr];
endmodule
`default_nettype wire

// >>> tb/pew_host_tb.sv
// Purpose: Self-checking bench for the page-write host and device model.
// Assumes: Shortened window and cycle-time parameters.
// Notes: Undriven data pins show a changing pattern, never a held value.
`timescale 1ns/1ns
`default_nettype none
module pew_host_tb;
   logic i_clk_sys = 0;
   logic i_reset_n = 0;
   logic valid = 0, pre = 0, last = 0, id = 0, slow = 0, flt = 0;
   pew_pkg::pew_op_t op = pew_pkg::OP_READ;
   logic [14:0] addr = 15'h0000;
   logic [7:0] data = 8'h00;
   logic ready, busy, rd_v, done, tmo, ce_n, oe_n, we_n, h_oe, m_oe, idm;
   logic [14:0] pa;
   logic [7:0] rd_d, h_dq, m_dq;
   wire [7:0] dq = h_oe ? h_dq : m_oe ? m_dq : (flt ? 8'hA5 : 8'h5A);
   int num_errors = 0;
   int n_tests = 0;
   always #10 i_clk_sys = !i_clk_sys;
   always @(posedge i_clk_sys) flt <= !flt;
   pew_host #(.LOAD_CYC(200), .TWC_CYC(400)) pew_host_i (
      .i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n), .i_cmd_valid(valid),
      .i_cmd_op(op), .i_cmd_addr(addr), .i_cmd_data(data),
      .i_cmd_prefix(pre), .i_cmd_last(last), .i_cmd_id(id),
      .o_cmd_ready(ready), .o_busy(busy), .o_rd_valid(rd_v),
      .o_rd_data(rd_d), .o_wr_done(done), .o_wr_timeout(tmo),
      .o_ce_n(ce_n), .o_oe_n(oe_n), .o_we_n(we_n), .o_addr(pa),
      .o_dq_out(h_dq), .o_dq_oe(h_oe), .i_dq_in(dq), .o_id_mode(idm));
   pew_eeprom_model #(.LOAD_CYC(200)) pew_eeprom_model_i (
      .i_clk_sys(i_clk_sys), .i_ce_n(ce_n), .i_oe_n(oe_n), .i_we_n(we_n),
      .i_addr(pa), .i_dq(dq), .i_id_mode(idm), .i_slow(slow),
      .o_dq(m_dq), .o_dq_oe(m_oe));
   task automatic chk(input logic [7:0] got, exp, input string m);
      n_tests++;
      if (got !== exp)
      begin
         $display("unexpected at %0t: %s got %h want %h", $time, m, got, exp);
         num_errors++;
      end
   endtask
   task automatic test_done;
      $display("mismatches %0d, comparisons %0d", num_errors, n_tests);
      if (num_errors == 0 && n_tests > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic hang(input string m);
      $display("unexpected at %0t: %s never finished", $time, m);
      num_errors++;
      test_done();
   endtask
   task automatic tick;
      @(posedge i_clk_sys);
      #2;
   endtask
   task automatic t_cmd(input pew_pkg::pew_op_t o, input logic [14:0] a,
      input logic [7:0] d, input logic p, l, i);
      int k;
      tick();
      op = o;
      addr = a;
      data = d;
      pre = p;
      last = l;
      id = i;
      valid = 1;
      for (k = 0; k < 2000 && ready !== 1'b1; k++) tick();
      if (ready !== 1'b1) hang("command");
      tick();
      valid = 0;
   endtask
   task automatic t_done(input logic to);
      int k;
      for (k = 0; k < 3000 && done !== 1'b1 && tmo !== 1'b1; k++) tick();
      if (done !== 1'b1 && tmo !== 1'b1) hang("write");
      chk({7'h00, tmo}, {7'h00, to}, "timeout flag");
      if (done === 1'b1)
         chk({7'h00, pew_eeprom_model_i.prog}, 8'h00, "done too early");
   endtask
   task automatic t_wr(input logic [14:0] a, input logic [7:0] d,
      input logic p, i, to);
      t_cmd(pew_pkg::OP_WRITE, a, d, p, 1'b1, i);
      t_done(to);
   endtask
   task automatic t_rd(input logic [14:0] a, input logic i,
      input logic [7:0] exp, input string m);
      int k;
      t_cmd(pew_pkg::OP_READ, a, 8'h00, 1'b0, 1'b0, i);
      for (k = 0; k < 20 && rd_v !== 1'b1; k++) tick();
      if (rd_v !== 1'b1) hang("read");
      chk(rd_d, exp, m);
   endtask
   task automatic s_idle;
      chk({3'h0, busy, ce_n, oe_n, we_n, h_oe}, 8'h0E, "idle pins");
   endtask
   task automatic s_byte;
      t_wr(15'h0123, 8'hA5, 0, 0, 0);
      t_rd(15'h0123, 0, 8'hA5, "byte");
   endtask
   task automatic s_page;
      t_cmd(pew_pkg::OP_WRITE, 15'h0205, 8'h11, 0, 0, 0);
      t_cmd(pew_pkg::OP_WRITE, 15'h0200, 8'h22, 0, 0, 0);
      t_wr(15'h0205, 8'h33, 0, 0, 0);
      t_rd(15'h0205, 0, 8'h33, "reloaded byte");
      t_rd(15'h0200, 0, 8'h22, "page byte");
      t_rd(15'h0201, 0, 8'hFF, "unloaded byte");
   endtask
   task automatic s_lock;
      t_cmd(pew_pkg::OP_LOCK, 15'h0000, 8'h00, 0, 1, 0);
      t_done(0);
      t_wr(15'h0300, 8'h9A, 0, 0, 0);
      t_rd(15'h0300, 0, 8'hFF, "locked write");
      t_wr(15'h0301, 8'h44, 1, 0, 0);
      t_rd(15'h0301, 0, 8'h44, "prefixed write");
      t_rd(15'h0AAA, 0, 8'hFF, "sequence byte");
      t_cmd(pew_pkg::OP_UNLOCK, 15'h0000, 8'h00, 0, 1, 0);
      t_done(0);
      t_wr(15'h0302, 8'h55, 0, 0, 0);
      t_rd(15'h0302, 0, 8'h55, "unlocked write");
   endtask
   task automatic s_id;
      t_wr(15'h7FC5, 8'h6E, 0, 1, 0);
      t_rd(15'h7FC5, 1, 8'h6E, "id area");
      t_rd(15'h7FC5, 0, 8'hFF, "main array");
   endtask
   task automatic s_slow;
      int k;
      slow = 1;
      t_wr(15'h0400, 8'h77, 0, 0, 1);
      for (k = 0; k < 1000 && pew_eeprom_model_i.prog; k++) tick();
      slow = 0;
      t_rd(15'h0400, 0, 8'h77, "slow write");
   endtask
   initial
   begin
      repeat (20) @(posedge i_clk_sys);
      #2;
      i_reset_n = 1;
      s_idle();
      s_byte();
      s_page();
      s_lock();
      s_id();
      s_slow();
      test_done();
   end
endmodule
`default_nettype wire
